// ==== rtl/ira_cfg.svh ====
// Purpose: constants of the sideband request generator
// Assumes: byte offsets on the register port
// Notes: field positions refer to the command word
`ifndef IRA_CFG_SVH
`define IRA_CFG_SVH
`define IRA_OFS_CMD 12'h100
`define IRA_OFS_WFIFO 12'h104
`define IRA_OFS_ADDR 12'h108
`define IRA_LEN_MSB 3
`define IRA_TYPE_LSB 8
`define IRA_TYPE_MSB 11
`define IRA_MID_FLAG_BIT 10
`define IRA_STATUS_BIT 9
`define IRA_READ_BIT 8
`define IRA_ADDR_ONLY_BIT 12
`define IRA_BUSY_BIT 16
`define IRA_RST_WORD 32'h0000_0000
`define IRA_RST_BYTE 8'h00
`define IRA_FIFO_DEPTH 16
`endif

// ==== rtl/ira_pkg.sv ====
// Purpose: types of the sideband request generator
// Assumes: gray codes along idle, cmd, addr, len, data, wait
// Notes: none
package ira_pkg;
   typedef enum logic [2:0] {
      IRA_IDLE = 3'h0,
      IRA_CMD = 3'h1,
      IRA_ADDR = 3'h3,
      IRA_LEN = 3'h2,
      IRA_DATA = 3'h6,
      IRA_WAIT = 3'h4
   } ira_state_t;

   typedef struct packed {
      ira_state_t st;
      logic busy;
      logic valid;
      logic first;
      logic last;
      logic [7:0] data;
      logic [4:0] rem;
      logic [31:0] cmd;
      logic [31:0] addr;
      logic [31:0] rdata;
   } ira_top_st_t;
endpackage

// ==== rtl/ira_fifo_if.sv ====
// Purpose: link between the request generator and its write fifo
// Assumes: one clock
// Notes: rdata shows the head entry while not empty
`timescale 1ns/10ps
interface ira_fifo_if #(parameter int W = 8);
   logic push;
   logic [W-1:0] wdata;
   logic pop;
   logic [W-1:0] rdata;
   logic empty;
   logic full;
   modport fifo (input push, input wdata, input pop, output rdata, output empty, output full);
   modport user (output push, output wdata, output pop, input rdata, input empty, input full);
endinterface

// ==== rtl/ira_wr_fifo.sv ====
// Purpose: byte fifo holding write payload
// Assumes: push when full and pop when empty are dropped
// Notes: storage in flip-flops
`timescale 1ns/10ps
module ira_wr_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   input wire logic clk,
   input wire logic rst,
   ira_fifo_if.fifo f
);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } ira_fifo_st_t;

   ira_fifo_st_t s;
   ira_fifo_st_t next_s;
   logic do_push;
   logic do_pop;

   assign f.empty = (s.cnt == '0);
   assign f.full = (s.cnt == (AW+1)'(DEPTH));
   assign f.rdata = s.mem[s.rp];
   assign do_push = f.push && !f.full;
   assign do_pop = f.pop && !f.empty;

   always_comb begin
      next_s = s;
      if (do_push) begin
         next_s.mem[s.wp] = f.wdata;
         next_s.wp = s.wp + 1'b1;
      end
      if (do_pop) begin
         next_s.rp = s.rp + 1'b1;
      end
      next_s.cnt = s.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   a_fifo_count: assert property (@(posedge clk) disable iff (rst)
      (do_push && !do_pop) |=> (s.cnt == $past(s.cnt) + 1'b1))
      else $error("fifo count did not grow on push");
endmodule // ira_wr_fifo

// ==== rtl/ira_req_gen.sv ====
// Purpose: turns register writes into sideband request frames
// Assumes: register port and reply pulse on I_MCLK
// Notes: frame bytes leave on a valid/ready stream, first and last mark start and stop
`timescale 1ns/10ps
`include "ira_cfg.svh"
module ira_req_gen import ira_pkg::*; (
   input wire logic I_MCLK,
   input wire logic I_RST,
   input wire logic I_REG_WR,
   input wire logic I_REG_RD,
   input wire logic [11:0] I_REG_ADDR,
   input wire logic [31:0] I_REG_WDATA,
   output logic [31:0] O_REG_RDATA,
   output logic O_TX_VALID,
   output logic [7:0] O_TX_DATA,
   output logic O_TX_FIRST,
   output logic O_TX_LAST,
   input wire logic I_TX_READY,
   input wire logic I_REPLY_DONE,
   output logic O_BUSY
);
   ira_top_st_t s;
   ira_top_st_t next_s;
   ira_fifo_if #(.W(8)) fif ();
   logic cmd_wr;
   logic adv;
   logic free;
   logic addr_only;
   logic mid_flag;
   logic is_read;
   logic new_addr_only;
   logic new_mid_flag;

   ira_wr_fifo #(.W(8), .DEPTH(`IRA_FIFO_DEPTH), .AW(4)) u_fifo (
      .clk(I_MCLK),
      .rst(I_RST),
      .f(fif.fifo)
   );

   assign cmd_wr = I_REG_WR && (I_REG_ADDR == `IRA_OFS_CMD);
   assign fif.push = I_REG_WR && (I_REG_ADDR == `IRA_OFS_WFIFO);
   assign fif.wdata = I_REG_WDATA[7:0];
   assign adv = s.valid && I_TX_READY;
   assign free = !s.valid || adv;
   // write status carries no length, like the address-only forms
   assign addr_only = s.cmd[`IRA_ADDR_ONLY_BIT] || s.cmd[`IRA_STATUS_BIT];
   assign mid_flag = s.cmd[`IRA_MID_FLAG_BIT];
   assign is_read = s.cmd[`IRA_READ_BIT];
   assign new_addr_only = I_REG_WDATA[`IRA_ADDR_ONLY_BIT] || I_REG_WDATA[`IRA_STATUS_BIT];
   assign new_mid_flag = I_REG_WDATA[`IRA_MID_FLAG_BIT];

   always_comb begin
      next_s = s;
      fif.pop = 1'b0;
      if (adv) begin
         next_s.valid = 1'b0;
         next_s.first = 1'b0;
         next_s.last = 1'b0;
      end
      if (I_REG_WR && (I_REG_ADDR == `IRA_OFS_ADDR)) begin
         next_s.addr = I_REG_WDATA;
      end
      next_s.rdata = `IRA_RST_WORD;
      if (I_REG_RD) begin
         if (I_REG_ADDR == `IRA_OFS_CMD) begin
            next_s.rdata = s.cmd;
            next_s.rdata[`IRA_BUSY_BIT] = s.busy;
         end else if (I_REG_ADDR == `IRA_OFS_ADDR) begin
            next_s.rdata = s.addr;
         end
      end
      unique case (s.st)
         IRA_IDLE: begin
            // a command is taken only while idle; later writes fall away
            if (cmd_wr) begin
               next_s.cmd = I_REG_WDATA;
               next_s.busy = 1'b1;
               next_s.valid = 1'b1;
               next_s.first = 1'b1;
               if (new_addr_only && !new_mid_flag) begin
                  next_s.data = s.addr[7:0];
                  next_s.last = 1'b1;
                  next_s.st = IRA_ADDR;
               end else begin
                  next_s.data = {I_REG_WDATA[`IRA_TYPE_MSB:`IRA_TYPE_LSB], 4'h0};
                  next_s.last = 1'b0;
                  next_s.st = IRA_CMD;
               end
            end
         end
         IRA_CMD: begin
            if (adv) begin
               next_s.valid = 1'b1;
               next_s.data = s.addr[7:0];
               next_s.last = addr_only;
               next_s.st = IRA_ADDR;
            end
         end
         IRA_ADDR: begin
            if (adv) begin
               if (addr_only) begin
                  next_s.st = IRA_WAIT;
               end else begin
                  next_s.valid = 1'b1;
                  next_s.data = {4'h0, s.cmd[`IRA_LEN_MSB:0]};
                  next_s.last = is_read;
                  next_s.st = IRA_LEN;
               end
            end
         end
         IRA_LEN: begin
            if (adv) begin
               next_s.rem = {1'b0, s.cmd[`IRA_LEN_MSB:0]} + 5'h1;
               next_s.st = is_read ? IRA_WAIT : IRA_DATA;
            end
         end
         IRA_DATA: begin
            if (free) begin
               if (s.rem == 5'h0) begin
                  next_s.st = IRA_WAIT;
               end else if (!fif.empty) begin
                  fif.pop = 1'b1;
                  next_s.valid = 1'b1;
                  next_s.data = fif.rdata;
                  next_s.last = (s.rem == 5'h1);
                  next_s.rem = s.rem - 5'h1;
               end
            end
         end
         IRA_WAIT: begin
            if (I_REPLY_DONE) begin
               next_s.busy = 1'b0;
               next_s.st = IRA_IDLE;
            end
         end
         default: begin
            next_s = '0;
         end
      endcase
   end

   always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign O_REG_RDATA = s.rdata;
   assign O_TX_VALID = s.valid;
   assign O_TX_DATA = s.data;
   assign O_TX_FIRST = s.first;
   assign O_TX_LAST = s.last;
   assign O_BUSY = s.busy;

   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (I_RST);

   a_cmd_holdoff: assert property (s.busy && cmd_wr |=> $stable(s.cmd))
      else $error("command changed while busy");
   a_launch_first: assert property (!s.busy && cmd_wr |=> O_TX_VALID && O_TX_FIRST && O_BUSY)
      else $error("command write did not open a frame");
   a_cmd_byte: assert property (!s.busy && cmd_wr && !(new_addr_only && !new_mid_flag)
      |=> O_TX_DATA == {$past(I_REG_WDATA[11:8]), 4'h0})
      else $error("command byte does not carry the type");
   a_abort_frame: assert property (!s.busy && cmd_wr && new_addr_only && !new_mid_flag
      |=> O_TX_FIRST && O_TX_LAST && O_TX_DATA == s.addr[7:0])
      else $error("unflagged address-only frame is not address alone");
   a_hold_byte: assert property (O_TX_VALID && !I_TX_READY |=> O_TX_VALID && $stable(O_TX_DATA))
      else $error("frame byte dropped under back-pressure");
   a_len_byte: assert property (s.st == IRA_LEN && O_TX_VALID |-> O_TX_DATA == {4'h0, s.cmd[3:0]})
      else $error("length byte wrong");
   a_read_stop: assert property (s.st == IRA_LEN && is_read |-> O_TX_LAST)
      else $error("read frame carries more than length");
   a_addr_only_stop: assert property (s.st == IRA_ADDR && addr_only |-> O_TX_LAST)
      else $error("address-only frame carries a length");
   a_mid_flag_kept: assert property (s.st == IRA_CMD && O_TX_VALID |-> O_TX_DATA[6] == mid_flag)
      else $error("flag missing from command byte");
   a_pop_order: assert property (fif.pop |=> O_TX_DATA == $past(fif.rdata) && O_TX_VALID)
      else $error("payload byte not taken from fifo head");
   // a new command may open a frame right after release, so only the release cycle is checked
   a_reply_idle: assert property (s.st == IRA_WAIT && I_REPLY_DONE |=> !O_BUSY && !O_TX_VALID)
      else $error("reply did not release the generator");
   a_first_start: assert property (s.st == IRA_LEN || s.st == IRA_DATA |-> !O_TX_FIRST)
      else $error("start mark on a later frame byte");
   a_len_skip: assert property (s.st == IRA_LEN |-> !addr_only)
      else $error("address-only frame reached the length byte");
   a_write_open: assert property (s.st == IRA_LEN && !is_read |-> !O_TX_LAST)
      else $error("write frame stopped before its payload");
   a_data_last: assert property (s.st == IRA_DATA && O_TX_VALID |-> O_TX_LAST == (s.rem == 5'h0))
      else $error("stop mark not on the last counted payload byte");
   a_wait_quiet: assert property (s.st == IRA_WAIT |-> !O_TX_VALID && O_BUSY)
      else $error("frame still open while awaiting reply");
   a_idle_quiet: assert property (s.st == IRA_IDLE |-> !O_BUSY && !O_TX_VALID)
      else $error("generator busy while idle");
   a_addr_read: assert property (I_REG_RD && I_REG_ADDR == `IRA_OFS_ADDR |=> O_REG_RDATA == $past(s.addr))
      else $error("target address readback wrong");

   c_write_frame: cover property (s.st == IRA_DATA && O_TX_LAST && adv);
   c_read_frame: cover property (s.st == IRA_LEN && is_read && adv);
   c_abort_frame: cover property (s.st == IRA_ADDR && O_TX_FIRST && O_TX_LAST && adv);
   c_holdoff: cover property (s.busy && cmd_wr);
   c_stall: cover property (O_TX_VALID && !I_TX_READY);
endmodule // ira_req_gen

// ==== verification/ira_sink_model.sv ====
// Purpose: far-side model that takes request frame bytes and answers each frame
// Assumes: ready and reply_done change at the falling edge, bytes taken on the rising edge
// Notes: slow mode stalls ready two cycles out of four
`timescale 1ns/10ps
module ira_sink_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic slow,
   input wire logic valid,
   input wire logic [7:0] data,
   input wire logic first,
   input wire logic last,
   output logic ready,
   output logic reply_done
);
   logic [9:0] got[$];
   logic [2:0] cnt = 3'h0;
   logic [2:0] wcnt = 3'h0;
   initial begin
      ready = 1'b0;
      reply_done = 1'b0;
   end
   // capture each taken byte with its start and stop marks
   always @(posedge clk) begin
      if (wcnt != 3'h0) begin
         wcnt <= wcnt - 3'h1;
      end
      if (!rst && valid && ready) begin
         got.push_back({first, last, data});
         if (last) begin
            wcnt <= 3'h6;
         end
      end
   end
   // answer only after the frame has ended, never while it runs
   always @(negedge clk) begin
      cnt <= cnt + 3'h1;
      ready <= !rst && (!slow || cnt[1]);
      reply_done <= (wcnt == 3'h1);
   end
endmodule // ira_sink_model

// ==== verification/ira_req_gen_tb_top.sv ====
// Purpose: register-driven checks of the request generator frames
// Assumes: sink model answers every frame after its stop byte
// Notes: one table entry per command tested, some types repeated with other lengths or flags
`timescale 1ns/10ps
module ira_req_gen_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic slow = 1'b0;
   logic [11:0] ad = 12'h000;
   logic [31:0] wd = 32'h0000_0000;
   logic [31:0] rdat;
   logic [31:0] r;
   logic valid, first, last, ready, done, busy;
   logic [7:0] data;
   int n_mismatch = 0;
   int n_compared = 0;
   logic [31:0] cmds[11] = '{32'h0000_0401, 32'h0000_0000, 32'h0000_0503, 32'h0000_0102, 32'h0000_1400,
      32'h0000_1500, 32'h0000_1000, 32'h0000_1100, 32'h0000_0600, 32'h0000_0200, 32'h0000_040F};
   always #10 clk = ~clk;
   ira_req_gen ira_req_gen_inst (.I_MCLK(clk), .I_RST(rst), .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_ADDR(ad),
      .I_REG_WDATA(wd), .O_REG_RDATA(rdat), .O_TX_VALID(valid), .O_TX_DATA(data), .O_TX_FIRST(first),
      .O_TX_LAST(last), .I_TX_READY(ready), .I_REPLY_DONE(done), .O_BUSY(busy));
   ira_sink_model ira_sink_model_inst (.clk(clk), .rst(rst), .slow(slow), .valid(valid), .data(data),
      .first(first), .last(last), .ready(ready), .reply_done(done));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wreg(input logic [11:0] a, input logic [31:0] d);
      @(negedge clk);
      wr = 1'b1;
      ad = a;
      wd = d;
      @(negedge clk);
      wr = 1'b0;
   endtask
   task automatic rreg(input logic [11:0] a, output logic [31:0] d);
      @(negedge clk);
      rd = 1'b1;
      ad = a;
      @(negedge clk);
      rd = 1'b0;
      d = rdat;
   endtask
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      end_of_test();
   end
   initial begin
      logic [31:0] c;
      logic [7:0] b;
      logic [9:0] exp[$];
      repeat (8) @(negedge clk);
      rst = 1'b0;
      rreg(12'h100, r);
      chk(r, 32'h0000_0000);
      rreg(12'h108, r);
      chk(r, 32'h0000_0000);
      rreg(12'h104, r);
      chk(r, 32'h0000_0000);
      rreg(12'h10C, r);
      chk(r, 32'h0000_0000);
      for (int k = 0; k < 11; k++) begin
         c = cmds[k];
         slow = k[0];
         ira_sink_model_inst.got.delete();
         wreg(12'h108, 32'h0000_0300 + k);
         if (c[12] | c[9]) begin
            // address-only and write status carry no length byte
            if (c[10]) begin
               exp = '{{2'b00, c[11:8], 4'h0}, {2'b00, 8'(k)}};
            end else begin
               exp = '{{2'b00, 8'(k)}};
            end
         end else begin
            exp = '{{2'b00, c[11:8], 4'h0}, {2'b00, 8'(k)}, {2'b00, 4'h0, c[3:0]}};
            for (int i = 0; i <= c[3:0] && !c[8]; i++) begin
               b = 8'(8'h11 * k + i);
               wreg(12'h104, {24'h00_0000, b});
               exp.push_back({2'b00, b});
            end
         end
         exp[0][9] = 1'b1;
         exp[exp.size() - 1][8] = 1'b1;
         wreg(12'h100, c);
         rreg(12'h100, r);
         chk({31'h0, r[16]}, 32'h0000_0001);
         chk({19'h0, r[12:0]}, {19'h0, c[12:0]});
         wreg(12'h100, 32'h0000_1000);
         rreg(12'h100, r);
         chk({19'h0, r[12:0]}, {19'h0, c[12:0]});
         for (int t = 0; t < 400 && busy !== 1'b0; t++) begin
            @(negedge clk);
         end
         repeat (12) @(negedge clk);
         chk({31'h0, busy}, 32'h0000_0000);
         chk(ira_sink_model_inst.got.size(), exp.size());
         for (int i = 0; i < exp.size(); i++) begin
            chk({22'h0, ira_sink_model_inst.got[i]}, {22'h0, exp[i]});
         end
         $display("test %0d command %h done", k, c);
      end
      end_of_test();
   end
endmodule // ira_req_gen_tb_top
